/* File: rtl/iovf_fault_handler.v */
// Function
// - The fault threshold is a 16-bit linear-format voltage readable and writable by the host.
// - A separate 16-bit linear-format warning threshold is readable and writable by the host.
// - Response code 00 keeps the output running through a fault.
// - Response code 01 keeps running for the delay, then follows the retry code if the fault remains.
// - Response code 10 turns the output off at once and then follows the retry code.
// - Response code 11 holds the output off until the fault is cleared by any clearing event.
// - Retry code 000 makes no restart and holds the output off until cleared.
// - Retry codes 001 to 110 make that many restarts, then hold the output off until cleared.
// - Retry code 111 retries without limit until commanded off or another fault stops it.
// - The delay code selects two to the power of the code time units, 1 to 128.
// - The delay serves as continued-run time and as spacing between restart starts.
// - The length of one time unit comes from a separate configuration value.
`timescale 1ns/1ps
`include "iovf_map.vh"

module iovf_fault_handler #(
  parameter UNIT_W = 16
) (
  input  wire              ref_clk_in,
  input  wire              reset_n_in,
  input  wire [7:0]        cmd_code_in,
  input  wire              cmd_wr_in,
  input  wire [15:0]       cmd_wdata_in,
  output reg  [15:0]       cmd_rdata_out,
  input  wire              clear_faults_in,
  input  wire              status_clr_in,
  input  wire              run_enable_in,
  input  wire              other_fault_in,
  input  wire [15:0]       vin_meas_in,
  input  wire [UNIT_W-1:0] unit_cycles_in,
  output reg               output_enable_out,
  output reg               ov_fault_out,
  output reg               ov_warn_out,
  output reg  [2:0]        retry_count_out
);

  // One-hot states
  localparam [3:0] ST_RUN   = 4'h1;
  localparam [3:0] ST_DELAY = 4'h2;
  localparam [3:0] ST_WAIT  = 4'h4;
  localparam [3:0] ST_LATCH = 4'h8;

  reg  [15:0] fault_thr_ff;
  reg  [7:0]  reaction_ff;
  reg  [15:0] warn_thr_ff;
  reg  [3:0]  state_ff;
  reg  [3:0]  nxt_state;
  reg  [2:0]  nxt_retry_count;
  reg         nxt_timer_start;
  reg         timer_start_ff;
  wire        timer_done;
  wire [1:0]  resp_code;
  wire [2:0]  retry_code;
  wire [2:0]  delay_code;
  wire        over_fault;
  wire        over_warn;
  wire        fault_cleared;
  wire        may_retry;

  ////////////////////////////////////////////////////////////////////////////
  // Linear format to a plain magnitude; negative values count as zero
  function [41:0] lin_mag;
    input [15:0] v;
    reg   [4:0]  sh;
    begin
      sh      = v[`IOVF_LIN_EXP_MSB:`IOVF_LIN_EXP_LSB] ^ 5'h10;
      lin_mag = v[`IOVF_LIN_SIGN] ? 42'h000_0000_0000 : ({32'h0000_0000, v[9:0]} << sh);
    end
  endfunction

  // Full decode so thresholds and readings may use different exponents
  assign over_fault = lin_mag(vin_meas_in) > lin_mag(fault_thr_ff);
  assign over_warn  = lin_mag(vin_meas_in) > lin_mag(warn_thr_ff);

  assign resp_code  = reaction_ff[`IOVF_RESP_MSB:`IOVF_RESP_LSB];
  assign retry_code = reaction_ff[`IOVF_RETRY_MSB:`IOVF_RETRY_LSB];
  assign delay_code = reaction_ff[`IOVF_DELAY_MSB:`IOVF_DELAY_LSB];

  // Any event that clears the fault; the off half of an on/off cycle lives in the FSM
  assign fault_cleared = clear_faults_in | status_clr_in;

  // Another attempt is allowed while the budget lasts, or always for the endless code
  assign may_retry = (retry_code == `IOVF_RETRY_FOREVER) ||
                     (retry_count_out < retry_code);

  ////////////////////////////////////////////////////////////////////////////
  // Settings registers written by command code
  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fault_thr_ff <= `IOVF_RST_FAULT_THR;
      reaction_ff  <= `IOVF_RST_REACTION;
      warn_thr_ff  <= `IOVF_RST_WARN_THR;
    end else if (cmd_wr_in) begin
      case (cmd_code_in)
        `IOVF_OFS_FAULT_THR: fault_thr_ff <= cmd_wdata_in;
        `IOVF_OFS_REACTION:  reaction_ff  <= cmd_wdata_in[7:0];
        `IOVF_OFS_WARN_THR:  warn_thr_ff  <= cmd_wdata_in;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data follows the command code one cycle later; unknown codes read zero
  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cmd_rdata_out <= 16'h0000;
    end else begin
      case (cmd_code_in)
        `IOVF_OFS_FAULT_THR: cmd_rdata_out <= fault_thr_ff;
        `IOVF_OFS_REACTION:  cmd_rdata_out <= {8'h00, reaction_ff};
        `IOVF_OFS_WARN_THR:  cmd_rdata_out <= warn_thr_ff;
        default:             cmd_rdata_out <= 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags; a new event wins over a clear in the same cycle
  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ov_fault_out <= 1'b0;
      ov_warn_out  <= 1'b0;
    end else begin
      ov_fault_out <= over_fault | (ov_fault_out & ~fault_cleared);
      ov_warn_out  <= over_warn  | (ov_warn_out  & ~fault_cleared);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reaction state machine
  always @* begin
    nxt_state       = state_ff;
    nxt_retry_count = retry_count_out;
    nxt_timer_start = 1'b0;
    case (state_ff)
      ST_RUN: begin
        if (run_enable_in && !other_fault_in && over_fault) begin
          case (resp_code)
            `IOVF_RESP_IGNORE: nxt_state = ST_RUN;
            `IOVF_RESP_DELAYED: begin
              nxt_state       = ST_DELAY;
              nxt_timer_start = 1'b1;
            end
            `IOVF_RESP_DISABLE: begin
              if (retry_code == `IOVF_RETRY_NONE) begin
                nxt_state = ST_LATCH;
              end else begin
                nxt_state       = ST_WAIT;
                nxt_timer_start = 1'b1;
              end
            end
            default: nxt_state = ST_LATCH;
          endcase
        end
      end
      ST_DELAY: begin
        // Output stays on until the delay ends
        if (timer_done) begin
          if (!over_fault) begin
            nxt_state = ST_RUN;
          end else if (retry_code == `IOVF_RETRY_NONE) begin
            nxt_state = ST_LATCH;
          end else begin
            nxt_state       = ST_WAIT;
            nxt_timer_start = 1'b1;
          end
        end
      end
      ST_WAIT: begin
        // One attempt per delay interval; a clean input means the restart held
        if (timer_done) begin
          if (!over_fault) begin
            nxt_state       = ST_RUN;
            nxt_retry_count = 3'h0;
          end else if (may_retry) begin
            nxt_timer_start = 1'b1;
            if (retry_code != `IOVF_RETRY_FOREVER) begin
              nxt_retry_count = retry_count_out + 3'h1;
            end
          end else begin
            nxt_state = ST_LATCH;
          end
        end
      end
      ST_LATCH: begin
        if (fault_cleared) begin
          nxt_state       = ST_RUN;
          nxt_retry_count = 3'h0;
        end
      end
      default: nxt_state = ST_RUN;
    endcase
    // Commanded off or stopped by another fault ends every reaction
    if (!run_enable_in || other_fault_in) begin
      nxt_state       = ST_RUN;
      nxt_retry_count = 3'h0;
      nxt_timer_start = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State, counter and output enable registers
  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_ff          <= ST_RUN;
      retry_count_out   <= 3'h0;
      timer_start_ff    <= 1'b0;
      output_enable_out <= 1'b0;
    end else begin
      state_ff          <= nxt_state;
      retry_count_out   <= nxt_retry_count;
      timer_start_ff    <= nxt_timer_start;
      // Output is on in RUN and DELAY only, and only while enabled
      output_enable_out <= run_enable_in & ~other_fault_in &
                           (nxt_state[0] | nxt_state[1]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Delay timer; unit length comes in from the configuration side
  iovf_delay_timer #(
    .UNIT_W (UNIT_W)
  ) u_delay_timer (
    .ref_clk_in     (ref_clk_in),
    .reset_n_in     (reset_n_in),
    .start_in       (timer_start_ff),
    .stop_in        (state_ff[0] | state_ff[3]),
    .delay_code_in  (delay_code),
    .unit_cycles_in (unit_cycles_in),
    .done_out       (timer_done)
  );

endmodule

/* File: rtl/iovf_map.vh */
`ifndef IOVF_MAP_VH
`define IOVF_MAP_VH

// Command codes of the three settings
`define IOVF_OFS_FAULT_THR   8'h55
`define IOVF_OFS_REACTION    8'h56
`define IOVF_OFS_WARN_THR    8'h57

// Reaction register field positions
`define IOVF_RESP_MSB        7
`define IOVF_RESP_LSB        6
`define IOVF_RETRY_MSB       5
`define IOVF_RETRY_LSB       3
`define IOVF_DELAY_MSB       2
`define IOVF_DELAY_LSB       0

// Response codes
`define IOVF_RESP_IGNORE     2'h0
`define IOVF_RESP_DELAYED    2'h1
`define IOVF_RESP_DISABLE    2'h2
`define IOVF_RESP_LATCH      2'h3

// Retry codes
`define IOVF_RETRY_NONE      3'h0
`define IOVF_RETRY_FOREVER   3'h7

// Linear format fields
`define IOVF_LIN_EXP_MSB     15
`define IOVF_LIN_EXP_LSB     11
`define IOVF_LIN_SIGN        10

// Reset values of the settings
`define IOVF_RST_FAULT_THR   16'h0000
`define IOVF_RST_REACTION    8'h80
`define IOVF_RST_WARN_THR    16'h0000

`endif

/* File: rtl/iovf_delay_timer.v */
`timescale 1ns/1ps
`include "iovf_map.vh"

module iovf_delay_timer #(
  parameter UNIT_W = 16
) (
  input  wire              ref_clk_in,
  input  wire              reset_n_in,
  input  wire              start_in,
  input  wire              stop_in,
  input  wire [2:0]        delay_code_in,
  input  wire [UNIT_W-1:0] unit_cycles_in,
  output reg               done_out
);

  reg              run_ff;
  reg [UNIT_W-1:0] div_ff;
  reg [7:0]        units_ff;
  wire             unit_tick;
  wire [7:0]       units_goal;

  // Divider gives one enable pulse per time unit; zero length acts as one cycle
  assign unit_tick  = run_ff && (div_ff + {{(UNIT_W-1){1'b0}}, 1'b1} >= unit_cycles_in);
  assign units_goal = 8'h01 << delay_code_in;

  ////////////////////////////////////////////////////////////////////////////
  // Count units up to two to the power of the delay code
  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      run_ff   <= 1'b0;
      div_ff   <= {UNIT_W{1'b0}};
      units_ff <= 8'h00;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        run_ff   <= 1'b1;
        div_ff   <= {UNIT_W{1'b0}};
        units_ff <= 8'h00;
      end else if (stop_in) begin
        run_ff <= 1'b0;
      end else if (unit_tick) begin
        div_ff <= {UNIT_W{1'b0}};
        if (units_ff + 8'h01 == units_goal) begin
          run_ff   <= 1'b0;
          done_out <= 1'b1;
        end else begin
          units_ff <= units_ff + 8'h01;
        end
      end else if (run_ff) begin
        div_ff <= div_ff + {{(UNIT_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

/* File: verification/iovf_fault_handler_monitor.sv */
`timescale 1ns/1ps
module iovf_fault_handler_monitor #(
  parameter UNIT_W = 16
) (
  input wire              ref_clk_in,
  input wire              reset_n_in,
  input wire [7:0]        cmd_code_in,
  input wire              cmd_wr_in,
  input wire [15:0]       cmd_wdata_in,
  input wire [15:0]       cmd_rdata_out,
  input wire              clear_faults_in,
  input wire              status_clr_in,
  input wire              run_enable_in,
  input wire              other_fault_in,
  input wire [15:0]       vin_meas_in,
  input wire [UNIT_W-1:0] unit_cycles_in,
  input wire              output_enable_out,
  input wire              ov_fault_out,
  input wire              ov_warn_out,
  input wire [2:0]        retry_count_out
);
  reg  [15:0] fthr_ff;
  reg  [15:0] wthr_ff;
  reg  [7:0]  react_ff;
  wire        mapped;
  wire        held;
  ////////////////////////////////////////
  // Shadow settings rebuilt from writes
  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fthr_ff <= 16'h0000;
      wthr_ff <= 16'h0000;
      react_ff <= 8'h80;
    end else if (cmd_wr_in) begin
      if (cmd_code_in == 8'h55) fthr_ff <= cmd_wdata_in;
      if (cmd_code_in == 8'h56) react_ff <= cmd_wdata_in[7:0];
      if (cmd_code_in == 8'h57) wthr_ff <= cmd_wdata_in;
    end
  end
  // Codes 0x55 to 0x57 only
  assign mapped = cmd_code_in[7:2] == 6'h15 && cmd_code_in[1:0] != 2'h0;
  // No way out of a latch while nothing clears it; two quiet cycles, as an off-on cycle restarts
  assign held = run_enable_in && !other_fault_in && !clear_faults_in && !status_clr_in;
  ////////////////////////////////////////
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  a_read_fault_thr: assert property (cmd_code_in == 8'h55
    |=> cmd_rdata_out == $past(fthr_ff)) else $error("fault threshold read wrong");
  a_read_warn_thr: assert property (cmd_code_in == 8'h57
    |=> cmd_rdata_out == $past(wthr_ff)) else $error("warning threshold read wrong");
  a_read_reaction: assert property (cmd_code_in == 8'h56
    |=> cmd_rdata_out == {8'h00, $past(react_ff)}) else $error("reaction read wrong");
  a_read_unmapped: assert property (!mapped |=> cmd_rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  a_ignore_keeps_on: assert property (react_ff[7:6] == 2'b00 && output_enable_out
    && run_enable_in && !other_fault_in && !cmd_wr_in |=> output_enable_out)
    else $error("output dropped while fault ignored");
  a_disable_at_fault: assert property ($rose(ov_fault_out) && react_ff[7]
    |-> !output_enable_out) else $error("output not off with fault");
  a_latch_holds_off: assert property (react_ff[7:6] == 2'b11 && ov_fault_out
    && !output_enable_out && held && $past(held) |=> !output_enable_out)
    else $error("latch released");
  a_retry_within_code: assert property (retry_count_out <= react_ff[5:3])
    else $error("retry count beyond code");
  a_off_when_stopped: assert property (!run_enable_in || other_fault_in
    |=> !output_enable_out) else $error("output on while stopped");
  c_delayed_fault: cover property ($rose(ov_fault_out) && react_ff[7:6] == 2'b01);
  c_six_retries: cover property (retry_count_out == 3'h6);
  c_restart_ok: cover property ($rose(output_enable_out) && ov_fault_out);
endmodule
bind iovf_fault_handler iovf_fault_handler_monitor #(.UNIT_W(UNIT_W)) monitor_inst (
  .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .cmd_code_in(cmd_code_in),
  .cmd_wr_in(cmd_wr_in), .cmd_wdata_in(cmd_wdata_in), .cmd_rdata_out(cmd_rdata_out),
  .clear_faults_in(clear_faults_in), .status_clr_in(status_clr_in),
  .run_enable_in(run_enable_in), .other_fault_in(other_fault_in),
  .vin_meas_in(vin_meas_in), .unit_cycles_in(unit_cycles_in),
  .output_enable_out(output_enable_out), .ov_fault_out(ov_fault_out),
  .ov_warn_out(ov_warn_out), .retry_count_out(retry_count_out));

/* File: verification/iovf_host_model.sv */
`timescale 1ns/1ps
module iovf_host_model (
  input  wire        ref_clk_in,
  input  wire [15:0] cmd_rdata_in,
  output reg  [7:0]  cmd_code_out,
  output reg         cmd_wr_out,
  output reg  [15:0] cmd_wdata_out
);
  ////////////////////////////////////////
  // Idle bus at time zero
  initial begin
    {cmd_code_out, cmd_wr_out, cmd_wdata_out} = 25'h000_0000;
  end
  // One-cycle strobe; released data is inverted, never left valid
  task wr(input [7:0] code, input [15:0] data); begin
    @(posedge ref_clk_in);
    #1 {cmd_code_out, cmd_wr_out, cmd_wdata_out} = {code, 1'b1, data};
    @(posedge ref_clk_in);
    #1 {cmd_wr_out, cmd_wdata_out} = {1'b0, ~data};
  end endtask
  // Read data is taken one edge after the code is seen
  task rd(input [7:0] code, output [15:0] data); begin
    @(posedge ref_clk_in);
    #1 cmd_code_out = code;
    @(posedge ref_clk_in);
    #1 data = cmd_rdata_in;
  end endtask
endmodule

/* File: verification/iovf_fault_handler_test.sv */
`timescale 1ns/1ps
module iovf_fault_handler_test;
  reg         ref_clk_in, reset_n_in, clr_f, clr_s, run_en, oth;
  reg  [15:0] vin, units, r, rng;
  wire [7:0]  code;
  wire        wr, oe, flt, wrn;
  wire [15:0] wdata, rdata;
  wire [2:0]  cnt;
  integer     failures, n_checks, cycles, i;
  ////////////////////////////////////////
  iovf_fault_handler #(.UNIT_W(16)) iovf_fault_handler_inst (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .cmd_code_in(code),
    .cmd_wr_in(wr), .cmd_wdata_in(wdata), .cmd_rdata_out(rdata), .clear_faults_in(clr_f),
    .status_clr_in(clr_s), .run_enable_in(run_en), .other_fault_in(oth),
    .vin_meas_in(vin), .unit_cycles_in(units), .output_enable_out(oe),
    .ov_fault_out(flt), .ov_warn_out(wrn), .retry_count_out(cnt));
  iovf_host_model iovf_host_model_inst (.ref_clk_in(ref_clk_in), .cmd_rdata_in(rdata),
    .cmd_code_out(code), .cmd_wr_out(wr), .cmd_wdata_out(wdata));
  ////////////////////////////////////////
  function [15:0] xs(input [15:0] s);
    reg [15:0] x;
    begin
      x = s ^ (s << 7);
      x = x ^ (x >> 9);
      xs = x ^ (x << 8);
    end
  endfunction
  // Cycles of continued run before the delayed reaction acts
  function [15:0] span(input [2:0] d, input [15:0] u);
    span = (16'h0001 << d) * u;
  endfunction
  task chk(input [15:0] got, input [15:0] exp); begin
    n_checks = n_checks + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  end endtask
  task cyc(input integer n); begin
    repeat (n) @(posedge ref_clk_in);
    #1;
  end endtask
  // Input back in range, then one clear pulse of either kind
  task recover(input sel); begin
    vin = 16'h0010;
    cyc(1);
    {clr_f, clr_s} = {~sel, sel};
    cyc(1);
    {clr_f, clr_s} = 2'b00;
    cyc(3);
  end endtask
  task wrap_up; begin
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end endtask
  ////////////////////////////////////////
  // Free clock and a hang guard well above the run length
  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    cycles = cycles + 1;
    if (cycles == 8000) begin
      failures = failures + 1;
      wrap_up;
    end
  end
  initial begin
    {reset_n_in, clr_f, clr_s, oth, run_en} = 5'b00001;
    {failures, n_checks, cycles} = 96'h0;
    // Zero input until thresholds are set; the reset thresholds would trip at once
    {vin, units, rng} = {16'h0000, 16'h0001, 16'h000A};
    cyc(20);
    reset_n_in = 1'b1;
    cyc(2);
    chk(oe, 16'h0001);
    iovf_host_model_inst.rd(8'h55, r); chk(r, 16'h0000);
    iovf_host_model_inst.rd(8'h56, r); chk(r, 16'h0080);
    iovf_host_model_inst.rd(8'h57, r); chk(r, 16'h0000);
    // Random words back to back; the unmapped code is dropped
    for (i = 0; i < 4; i = i + 1) begin
      rng = xs(rng);
      iovf_host_model_inst.wr(8'h55, rng);
      iovf_host_model_inst.wr(8'h57, ~rng);
      iovf_host_model_inst.wr(8'h56, rng);
      iovf_host_model_inst.wr(8'h58, rng);
      iovf_host_model_inst.rd(8'h55, r); chk(r, rng);
      iovf_host_model_inst.rd(8'h57, r); chk(r, ~rng);
      iovf_host_model_inst.rd(8'h56, r); chk(r, {8'h00, rng[7:0]});
      iovf_host_model_inst.rd(8'h58, r); chk(r, 16'h0000);
    end
    iovf_host_model_inst.wr(8'h55, 16'h0064);
    iovf_host_model_inst.wr(8'h57, 16'h0050);
    iovf_host_model_inst.wr(8'h56, 16'h0000);
    vin = 16'h005A;
    cyc(3);
    chk({oe, flt, wrn}, 16'h0005);
    vin = 16'h0070;
    cyc(20);
    chk({oe, flt, wrn}, 16'h0007);
    recover(1'b1);
    chk({oe, flt, wrn}, 16'h0004);
    // Disable and retry, every limited count from 0 to 6
    for (i = 0; i < 7; i = i + 1) begin
      iovf_host_model_inst.wr(8'h56, {8'h00, 2'b10, i[2:0], 3'b000});
      vin = 16'h0070;
      cyc(2);
      chk(oe, 16'h0000);
      cyc(150);
      chk({oe, cnt}, {1'b0, i[2:0]});
      recover(i[0]);
      chk({oe, cnt}, 16'h0008);
    end
    // Delayed reaction with a slow time unit
    units = 16'h0003;
    for (i = 0; i < 4; i = i + 1) begin
      iovf_host_model_inst.wr(8'h56, {8'h00, 2'b01, 3'b000, i[2:0]});
      vin = 16'h0070;
      cyc(span(i[2:0], units));
      chk(oe, 16'h0001);
      cyc(10);
      chk(oe, 16'h0000);
      recover(i[0]);
    end
    // Delayed reaction with one retry: fault gone before the delay ends, then fault held
    iovf_host_model_inst.wr(8'h56, 16'h004A);
    vin = 16'h0070;
    cyc(4);
    vin = 16'h0010;
    cyc(20);
    chk({oe, cnt}, 16'h0008);
    vin = 16'h0070;
    cyc(60);
    chk({oe, cnt}, 16'h0001);
    recover(1'b0);
    // Endless retry ends once the input is back in range
    iovf_host_model_inst.wr(8'h56, 16'h00B8);
    vin = 16'h0070;
    cyc(80);
    chk(oe, 16'h0000);
    vin = 16'h0010;
    cyc(40);
    chk({oe, cnt}, 16'h0008);
    // Latch held with the input back in range, then cleared by an off-on cycle
    iovf_host_model_inst.wr(8'h56, 16'h00C0);
    vin = 16'h0070;
    cyc(3);
    vin = 16'h0010;
    cyc(20);
    chk(oe, 16'h0000);
    run_en = 1'b0;
    cyc(2);
    run_en = 1'b1;
    cyc(3);
    chk(oe, 16'h0001);
    oth = 1'b1;
    cyc(2);
    chk(oe, 16'h0000);
    oth = 1'b0;
    cyc(3);
    chk(oe, 16'h0001);
    wrap_up;
  end
endmodule
